// File: bcst_pkg.sv
// Package for the bus cycle state timing calculator.
// Assumes a single synchronous clock domain and no software-visible registers.
`default_nettype none
package bcst_pkg;
  // Access targets for a bus cycle.
  typedef enum logic [2:0] {
    BCST_TGT_ONCHIP_MEM,
    BCST_TGT_MOD8,
    BCST_TGT_MOD16,
    BCST_TGT_EXT8,
    BCST_TGT_EXT16
  } bcst_target_e;

  localparam int CNT_W = 8;
  localparam int WAIT_W = 4;
  localparam int COST_W = 8;
  localparam int TOTAL_W = 16;

  // Fixed state costs per target and access kind.
  localparam logic [COST_W-1:0] COST_ONCHIP_MEM = 8'h02;
  localparam logic [COST_W-1:0] COST_MOD8_FETCH = 8'h06;
  localparam logic [COST_W-1:0] COST_MOD8_BYTE = 8'h03;
  localparam logic [COST_W-1:0] COST_MOD16_FETCH = 8'h03;
  localparam logic [COST_W-1:0] COST_EXT8_2ST_FETCH = 8'h04;
  localparam logic [COST_W-1:0] COST_EXT8_2ST_BYTE = 8'h02;
  localparam logic [COST_W-1:0] COST_EXT8_3ST_WORD_BASE = 8'h06;
  localparam logic [COST_W-1:0] COST_EXT8_3ST_BYTE_BASE = 8'h03;
  localparam logic [COST_W-1:0] COST_EXT16_2ST = 8'h02;
  localparam logic [COST_W-1:0] COST_EXT16_3ST_BASE = 8'h03;
  localparam logic [COST_W-1:0] COST_INTERNAL_OP = 8'h01;

  // Access conditions for one class of target.
  typedef struct packed {
    bcst_target_e target;
    logic three_state;
    logic [WAIT_W-1:0] wait_states;
  } bcst_access_s;

  // Per-instruction cycle counts.
  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] vector_read;
    logic [CNT_W-1:0] push_pop;
    logic [CNT_W-1:0] byte_access;
    logic [CNT_W-1:0] word_access;
    logic [CNT_W-1:0] internal_op;
  } bcst_counts_s;

  // Per-cycle state costs produced by the cost selector.
  typedef struct packed {
    logic [COST_W-1:0] fetch;
    logic [COST_W-1:0] vector_read;
    logic [COST_W-1:0] push_pop;
    logic [COST_W-1:0] byte_access;
    logic [COST_W-1:0] word_access;
    logic [COST_W-1:0] internal_op;
  } bcst_costs_s;
endpackage : bcst_pkg
`default_nettype wire

// File: bcst_cost_sel.sv
// Cost selector: state cost of one bus cycle class for given access conditions.
// Purely combinational; the caller registers its results.
`timescale 1ns/1ps
`default_nettype none
module bcst_cost_sel (
  input wire bcst_pkg::bcst_access_s acc_in,
  output logic [bcst_pkg::COST_W-1:0] fetch_cost_out,
  output logic [bcst_pkg::COST_W-1:0] byte_cost_out,
  output logic [bcst_pkg::COST_W-1:0] word_cost_out
);
  logic [bcst_pkg::COST_W-1:0] m1;
  logic [bcst_pkg::COST_W-1:0] m2;

  // Wait count widened once so the sums below stay at cost width.
  assign m1 = {{(bcst_pkg::COST_W-bcst_pkg::WAIT_W){1'b0}}, acc_in.wait_states};
  assign m2 = {m1[bcst_pkg::COST_W-2:0], 1'b0};

  // Wait states only count for 3-state external accesses.
  always_comb
  begin
    fetch_cost_out = bcst_pkg::COST_ONCHIP_MEM;
    byte_cost_out = bcst_pkg::COST_ONCHIP_MEM;
    word_cost_out = bcst_pkg::COST_ONCHIP_MEM;
    case (acc_in.target)
      bcst_pkg::BCST_TGT_ONCHIP_MEM:
      begin
        fetch_cost_out = bcst_pkg::COST_ONCHIP_MEM;
        byte_cost_out = bcst_pkg::COST_ONCHIP_MEM;
        word_cost_out = bcst_pkg::COST_ONCHIP_MEM;
      end
      bcst_pkg::BCST_TGT_MOD8:
      begin
        fetch_cost_out = bcst_pkg::COST_MOD8_FETCH;
        byte_cost_out = bcst_pkg::COST_MOD8_BYTE;
        word_cost_out = bcst_pkg::COST_MOD8_FETCH;
      end
      bcst_pkg::BCST_TGT_MOD16:
      begin
        // A 16-bit module moves a word in one cycle, so data costs match the fetch.
        fetch_cost_out = bcst_pkg::COST_MOD16_FETCH;
        byte_cost_out = bcst_pkg::COST_MOD16_FETCH;
        word_cost_out = bcst_pkg::COST_MOD16_FETCH;
      end
      bcst_pkg::BCST_TGT_EXT8:
      begin
        // A word on an 8-bit bus is two byte transfers, hence double cost.
        if (acc_in.three_state)
        begin
          fetch_cost_out = bcst_pkg::COST_EXT8_3ST_WORD_BASE + m2;
          byte_cost_out = bcst_pkg::COST_EXT8_3ST_BYTE_BASE + m1;
          word_cost_out = bcst_pkg::COST_EXT8_3ST_WORD_BASE + m2;
        end
        else
        begin
          fetch_cost_out = bcst_pkg::COST_EXT8_2ST_FETCH;
          byte_cost_out = bcst_pkg::COST_EXT8_2ST_BYTE;
          word_cost_out = bcst_pkg::COST_EXT8_2ST_FETCH;
        end
      end
      bcst_pkg::BCST_TGT_EXT16:
      begin
        if (acc_in.three_state)
        begin
          fetch_cost_out = bcst_pkg::COST_EXT16_3ST_BASE + m1;
        end
        else
        begin
          fetch_cost_out = bcst_pkg::COST_EXT16_2ST;
        end
        byte_cost_out = fetch_cost_out;
        word_cost_out = fetch_cost_out;
      end
      default:
      begin
        fetch_cost_out = bcst_pkg::COST_ONCHIP_MEM;
        byte_cost_out = bcst_pkg::COST_ONCHIP_MEM;
        word_cost_out = bcst_pkg::COST_ONCHIP_MEM;
      end
    endcase
  end
endmodule : bcst_cost_sel
`default_nettype wire

// File: bcst_calc.sv
// Instruction state-count calculator: takes the six cycle counts of one
// instruction and the access conditions, returns the total execution states.
// The cost table lives in bcst_cost_sel; this file sequences, captures and sums.
// Assumes inputs synchronous to ref_clk_in; a request is a one-cycle strobe.
// Assumes the caller waits for busy_out to fall before a new request, since a
// request made while busy is dropped without any indication.
`timescale 1ns/1ps
`default_nettype none
module bcst_calc (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire bcst_pkg::bcst_counts_s counts_in,
  input wire bcst_pkg::bcst_access_s code_acc_in,
  input wire bcst_pkg::bcst_access_s stack_acc_in,
  input wire bcst_pkg::bcst_access_s data_acc_in,
  output logic busy_out,
  output logic done_out,
  output logic [bcst_pkg::TOTAL_W-1:0] total_states_out,
  output bcst_pkg::bcst_costs_s costs_out
);
  // Three steps per request: wait for a start, look up the costs, add up.
  // The answer therefore always takes the same number of edges.
  typedef enum logic [1:0] {BCST_IDLE, BCST_COST, BCST_SUM} bcst_phase_e;

  // Everything the calculator remembers between edges, held in one register.
  // The access conditions sit here too, so that the answer belongs to the
  // conditions seen on the taking edge and not to whatever the inputs show later.
  typedef struct packed {
    bcst_phase_e phase;
    bcst_pkg::bcst_counts_s counts;
    bcst_pkg::bcst_access_s code_acc;
    bcst_pkg::bcst_access_s stack_acc;
    bcst_pkg::bcst_access_s data_acc;
    bcst_pkg::bcst_costs_s costs;
    logic busy;
    logic done;
    logic [bcst_pkg::TOTAL_W-1:0] total;
  } bcst_state_s;

  // Number of cycle kinds that are weighted and added; it is fixed by the
  // counts and costs structs and cannot be changed on its own.
  localparam int KINDS = 6;

  // Registered state and the value it takes at the next edge.
  bcst_state_s st;
  bcst_state_s next_st;

  // Captured conditions as the three cost selectors see them.
  bcst_pkg::bcst_access_s code_acc;
  bcst_pkg::bcst_access_s stack_acc;
  bcst_pkg::bcst_access_s data_acc;

  // Costs coming back from the selectors: code fetch, stack fetch, data byte and data word.
  logic [bcst_pkg::COST_W-1:0] code_fetch;
  logic [bcst_pkg::COST_W-1:0] stack_fetch;
  logic [bcst_pkg::COST_W-1:0] data_byte;
  logic [bcst_pkg::COST_W-1:0] data_word;

  // Per-kind factors, products and their sum.
  logic [bcst_pkg::CNT_W-1:0] kind_count [KINDS];
  logic [bcst_pkg::COST_W-1:0] kind_cost [KINDS];
  logic [bcst_pkg::TOTAL_W-1:0] kind_states [KINDS];
  logic [bcst_pkg::TOTAL_W-1:0] sum;

  // Code space: fetch and vector read cycles both use these conditions, since
  // vector tables are read from where the program lives.
  bcst_cost_sel u_code_sel (
    .acc_in(code_acc),
    .fetch_cost_out(code_fetch),
    .byte_cost_out(),
    .word_cost_out()
  );

  // Stack space: push and pop cycles.
  bcst_cost_sel u_stack_sel (
    .acc_in(stack_acc),
    .fetch_cost_out(stack_fetch),
    .byte_cost_out(),
    .word_cost_out()
  );

  // Data space: byte and word accesses. The fetch cost of this selector is
  // left open; data cycles never fetch.
  bcst_cost_sel u_data_sel (
    .acc_in(data_acc),
    .fetch_cost_out(),
    .byte_cost_out(data_byte),
    .word_cost_out(data_word)
  );

  // Counts of the six cycle kinds, in the order of the counts struct.
  assign kind_count[0] = st.counts.fetch;
  assign kind_count[1] = st.counts.vector_read;
  assign kind_count[2] = st.counts.push_pop;
  assign kind_count[3] = st.counts.byte_access;
  assign kind_count[4] = st.counts.word_access;
  assign kind_count[5] = st.counts.internal_op;

  // Captured costs, in the same order, so index k pairs a count with its cost.
  assign kind_cost[0] = st.costs.fetch;
  assign kind_cost[1] = st.costs.vector_read;
  assign kind_cost[2] = st.costs.push_pop;
  assign kind_cost[3] = st.costs.byte_access;
  assign kind_cost[4] = st.costs.word_access;
  assign kind_cost[5] = st.costs.internal_op;

  // One product per cycle kind. Both factors are widened to the total's width
  // first, so a large count times a large cost keeps its upper byte.
  for (genvar k = 0; k < KINDS; k++)
  begin : g_kind
    assign kind_states[k] = 16'(kind_count[k]) * 16'(kind_cost[k]);
  end

  // Weighted sum over the six kinds. It wraps at 16 bits; realistic counts
  // never come near that, so no overflow flag is kept.
  always_comb
  begin
    sum = 16'h0000;
    // A plain chain of adders; at six terms it is five adders deep, against three for a tree.
    for (int k = 0; k < KINDS; k++)
    begin
      sum = sum + kind_states[k];
    end
  end

  // Phase sequencer. A request is taken in idle only; the walk is then fixed:
  //   taking edge: counts and conditions captured, busy rises;
  //   next edge: costs captured from the selectors, which now see the new conditions;
  //   edge after: weighted sum registered, done pulses for one cycle, busy falls.
  // The cost step costs a cycle but keeps the selectors and the adder chain
  // in separate register stages, which is what sets the clock rate here.
  // A start in the done cycle is taken at once, so requests may follow every
  // third edge.
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.phase)
      BCST_IDLE:
      begin
        // A start seen while busy never reaches this branch, so it is dropped.
        if (start_in)
        begin
          next_st.counts = counts_in;
          // Conditions are taken on the same edge as the counts, so a later
          // change on the access inputs cannot leak into this answer.
          next_st.code_acc = code_acc_in;
          next_st.stack_acc = stack_acc_in;
          next_st.data_acc = data_acc_in;
          next_st.phase = BCST_COST;
          next_st.busy = 1'b1;
        end
      end
      BCST_COST:
      begin
        // Fetch cycles come from code space.
        next_st.costs.fetch = code_fetch;
        // Vector tables live in code space, pushes and pops in stack space.
        next_st.costs.vector_read = code_fetch;
        next_st.costs.push_pop = stack_fetch;
        next_st.costs.byte_access = data_byte;
        next_st.costs.word_access = data_word;
        // Internal cycles never touch the bus, so no condition applies.
        next_st.costs.internal_op = bcst_pkg::COST_INTERNAL_OP;
        next_st.phase = BCST_SUM;
      end
      BCST_SUM:
      begin
        // The total and the done pulse leave the same register together,
        // so a reader that sees done never sees a stale total.
        next_st.total = sum;
        next_st.done = 1'b1;
        next_st.busy = 1'b0;
        next_st.phase = BCST_IDLE;
      end
      default:
      begin
        // An unused phase code returns to idle rather than hanging busy.
        next_st.phase = BCST_IDLE;
        next_st.busy = 1'b0;
      end
    endcase
  end

  // The cost selectors see only the captured conditions, never the live inputs.
  assign code_acc = st.code_acc;
  assign stack_acc = st.stack_acc;
  assign data_acc = st.data_acc;

  // State register with synchronous active-low reset. Reset clears the costs
  // and the total as well, so a reader sees zeros rather than unknowns until
  // the first answer arrives.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      st <= '0;
      st.phase <= BCST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register, so none has logic after it
  // and none can glitch between edges.
  assign busy_out = st.busy;
  assign done_out = st.done;
  assign total_states_out = st.total;
  assign costs_out = st.costs;
endmodule : bcst_calc
`default_nettype wire

// File: bcst_far.sv
// Far-side model: the access conditions one target presents to the calculator.
// Assumes the bench picks the target, the slow access and any wait request.
`timescale 1ns/1ps
`default_nettype none
module bcst_far (
  input wire bcst_pkg::bcst_target_e tgt_in,
  input wire logic slow_in,
  input wire logic [3:0] wait_in,
  output var bcst_pkg::bcst_access_s acc_out
);
  // A slow device asks for waits; the calculator must stretch only 3-state cycles.
  always_comb
  begin
    acc_out.target = tgt_in;
    acc_out.three_state = slow_in;
    acc_out.wait_states = wait_in;
  end
endmodule : bcst_far
`default_nettype wire

// File: bcst_calc_props.sv
// Checker for the state-count calculator, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bcst_calc_props (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire bcst_pkg::bcst_counts_s counts_in,
  input wire bcst_pkg::bcst_access_s code_acc_in,
  input wire bcst_pkg::bcst_access_s stack_acc_in,
  input wire bcst_pkg::bcst_access_s data_acc_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [bcst_pkg::TOTAL_W-1:0] total_states_out,
  input wire bcst_pkg::bcst_costs_s costs_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Weighted sum; it wraps at 16 bits just as the total does.
  function automatic logic [15:0] wsum(bcst_pkg::bcst_counts_s n, bcst_pkg::bcst_costs_s c);
    logic [15:0] s;
    s = n.fetch * c.fetch + n.vector_read * c.vector_read + n.push_pop * c.push_pop;
    s = s + n.byte_access * c.byte_access + n.word_access * c.word_access + n.internal_op * c.internal_op;
    return s;
  endfunction : wsum
  // A taken request, then two busy cycles ending in the done pulse.
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_run;
    busy_out [*2] ##1 (done_out && !busy_out);
  endsequence
  chk_busy_done_walk: assert property (s_take |=> s_run) else $error("busy or done out of step");
  chk_total_sum: assert property (done_out |-> total_states_out == wsum($past(counts_in, 3), costs_out))
    else $error("total is not the weighted sum");
  chk_total_holds: assert property ($past(rstn_in) && !done_out |-> $stable(total_states_out))
    else $error("total moved without done");
  chk_internal_one: assert property (done_out |-> costs_out.internal_op == 8'h01)
    else $error("internal op cost wrong");
  chk_vector_as_fetch: assert property (done_out |-> costs_out.vector_read == costs_out.fetch)
    else $error("vector read cost differs from fetch");
  chk_mem_data_cost: assert property (done_out
    && $past(data_acc_in.target, 3) == bcst_pkg::BCST_TGT_ONCHIP_MEM
    |-> costs_out.byte_access == 8'h02 && costs_out.word_access == 8'h02)
    else $error("memory data cost wrong");
  chk_mod16_data: assert property (done_out
    && $past(data_acc_in.target, 3) == bcst_pkg::BCST_TGT_MOD16
    |-> costs_out.byte_access == 8'h03 && costs_out.word_access == 8'h03)
    else $error("module data cost wrong");
  chk_ext8_slow_word: assert property (done_out
    && $past(data_acc_in.target, 3) == bcst_pkg::BCST_TGT_EXT8
    && $past(data_acc_in.three_state, 3) |-> costs_out.word_access == 8'h06 + 2 * $past(data_acc_in.wait_states, 3))
    else $error("slow word cost wrong");
  chk_ext16_slow_fetch: assert property (done_out
    && $past(code_acc_in.target, 3) == bcst_pkg::BCST_TGT_EXT16
    && $past(code_acc_in.three_state, 3) |-> costs_out.fetch == 8'h03 + $past(code_acc_in.wait_states, 3))
    else $error("slow fetch cost wrong");
endmodule : bcst_calc_props
bind bcst_calc bcst_calc_props u_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .start_in(start_in),
  .counts_in(counts_in), .code_acc_in(code_acc_in), .stack_acc_in(stack_acc_in), .data_acc_in(data_acc_in),
  .busy_out(busy_out), .done_out(done_out), .total_states_out(total_states_out), .costs_out(costs_out));
`default_nettype wire

// File: bcst_calc_test.sv
// Bench for the state-count calculator.
// Assumes three far-side models give code, stack and data conditions.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module bcst_calc_test;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic start_in = 1'b0;
  logic busy_out, done_out;
  logic [15:0] total_states_out;
  bcst_pkg::bcst_costs_s costs_out;
  bcst_pkg::bcst_counts_s counts_in = '0;
  bcst_pkg::bcst_target_e tgt [3] = '{default: bcst_pkg::BCST_TGT_ONCHIP_MEM};
  logic slow [3] = '{default: 1'b0};
  logic [3:0] m [3] = '{default: 4'h0};
  bcst_pkg::bcst_access_s acc [3];
  int checks = 0, err_count = 0, cyc = 0;
  for (genvar i = 0; i < 3; i++)
  begin : g_far
    bcst_far far (.tgt_in(tgt[i]), .slow_in(slow[i]), .wait_in(m[i]), .acc_out(acc[i]));
  end
  bcst_calc dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .start_in(start_in), .counts_in(counts_in),
    .code_acc_in(acc[0]), .stack_acc_in(acc[1]), .data_acc_in(acc[2]), .busy_out(busy_out),
    .done_out(done_out), .total_states_out(total_states_out), .costs_out(costs_out));
  // Clock and a hang guard well beyond the fewer than a hundred cycles the run needs.
  initial forever #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test();
    end
  end
  // Cost of kind k (0 fetch, 1 byte, 2 word), worked out independently of the design.
  function automatic int cost(bcst_pkg::bcst_access_s a, int k);
    int w = a.wait_states;
    case (a.target)
      bcst_pkg::BCST_TGT_MOD8: return k == 1 ? 3 : 6;
      bcst_pkg::BCST_TGT_MOD16: return 3;
      bcst_pkg::BCST_TGT_EXT8: return a.three_state ? (k == 1 ? 3 + w : 6 + 2 * w) : (k == 1 ? 2 : 4);
      bcst_pkg::BCST_TGT_EXT16: return a.three_state ? 3 + w : 2;
      default: return 2;
    endcase
  endfunction : cost
  function automatic logic [15:0] expect_total(bcst_pkg::bcst_counts_s n);
    return 16'((n.fetch + n.vector_read) * cost(acc[0], 0) + n.push_pop * cost(acc[1], 0)
      + n.byte_access * cost(acc[2], 1) + n.word_access * cost(acc[2], 2) + n.internal_op);
  endfunction : expect_total
  task automatic set(input int i, input int t, input logic s, input logic [3:0] w);
    tgt[i] <= bcst_bcst_cast(t);
    slow[i] <= s;
    m[i] <= w;
  endtask : set
  function automatic bcst_pkg::bcst_target_e bcst_bcst_cast(int t);
    return bcst_pkg::bcst_target_e'(t);
  endfunction : bcst_bcst_cast
  // One request, held for a single edge, then the bounded wait for done.
  task automatic run(input bcst_pkg::bcst_counts_s n);
    int i;
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    counts_in <= n;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    for (i = 0; i < 8 && done_out !== 1'b1; i++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    `CHK("done", 1'b1, done_out)
    `CHK("total", expect_total(n), total_states_out)
  endtask : run
  // Two worked cases: external 16-bit 3-state with one wait, 8-bit modules.
  task automatic t_examples();
    @(posedge ref_clk_in);
    set(0, 4, 1'b1, 4'h1);
    set(1, 4, 1'b1, 4'h1);
    set(2, 1, 1'b0, 4'h0);
    run({8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00});
    `CHK("bitset", 16'h000E, total_states_out)
    run({8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00});
    `CHK("subcall", 16'h0018, total_states_out)
  endtask : t_examples
  // Every target, fast and slow, with the wait count at both ends.
  task automatic t_targets();
    for (int t = 0; t < 5; t++)
      for (int s = 0; s < 2; s++)
      begin
        @(posedge ref_clk_in);
        set(0, t, s[0], s ? 4'hF : 4'h0);
        set(1, (t + 1) % 5, s[0], 4'h7);
        set(2, (t + 2) % 5, s[0], s ? 4'hF - 4'(t) : 4'(t));
        run({8'h03, 8'h01, 8'h02, 8'h05, 8'h04, 8'h09});
        `CHK("byte", cost(acc[2], 1), costs_out.byte_access)
        `CHK("word", cost(acc[2], 2), costs_out.word_access)
        `CHK("pushpop", cost(acc[1], 0), costs_out.push_pop)
        `CHK("fetch", cost(acc[0], 0), costs_out.fetch)
        `CHK("internal", 1, costs_out.internal_op)
      end
  endtask : t_targets
  // Start held high: new counts while busy are ignored, retaken in the done cycle.
  task automatic t_b2b();
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    counts_in <= {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
    @(posedge ref_clk_in);
    counts_in <= {8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'hFF};
    repeat (3) @(posedge ref_clk_in);
    #1;
    `CHK("first", expect_total({8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04}), total_states_out)
    `CHK("busy", 1'b1, busy_out)
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("second", expect_total(counts_in), total_states_out)
  endtask : t_b2b
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (checks > 0 && err_count == 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Reset for ten cycles, confirm cleared outputs, then the scenarios.
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    #1;
    `CHK("reset", 66'h0, {busy_out, done_out, total_states_out, costs_out})
    t_examples();
    t_targets();
    t_b2b();
    end_of_test();
  end
endmodule : bcst_calc_test
`default_nettype wire
